// ===== design/spc_defs.vh
// constants of the serial port control register bank
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// configuration bus byte offsets
`define SPC_OFF_RX_DATA      8'h00
`define SPC_OFF_TX_DATA      8'h04
`define SPC_OFF_PORT_CTRL    8'h08

// data-port bus windows, selected by address bit 2
`define SPC_DP_WIN_BIT       2

// port control field positions
`define SPC_BIT_FREE_RUN     25
`define SPC_BIT_SOFT_STOP    24
`define SPC_BIT_FRAME_RST_N  23
`define SPC_BIT_RATE_RST_N   22
`define SPC_BIT_IRQ_SEL_HI   21
`define SPC_BIT_IRQ_SEL_LO   20
`define SPC_BIT_SYNC_ERR     19
`define SPC_BIT_TX_RST_N     16

// reset values
`define SPC_PORT_CTRL_RST    32'h0000_0000
`define SPC_TX_DATA_RST      32'h0000_0000

// transmit interrupt sources
`define SPC_IRQ_SEL_RSVD     2'h0
`define SPC_IRQ_SEL_BLOCK    2'h1
`define SPC_IRQ_SEL_FSYNC    2'h2
`define SPC_IRQ_SEL_SYNCERR  2'h3

// receive fifo shape
`define SPC_FIFO_WIDTH       32
`define SPC_FIFO_DEPTH       16
`define SPC_FIFO_AW          4

`endif

// ===== design/spc_regs.v
// serial port control register bank with receive fifo

module spc_fifo
#(
   parameter WIDTH = 32,
   parameter DEPTH = 16,
   parameter AW    = 4
)
(
   input  wire             clk,
   input  wire             rst,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_q;
   reg [AW-1:0]    rd_ptr_q;
   reg [AW:0]      count_q;
   wire            push;
   wire            pop;

   // full and empty come straight from the occupancy count
   assign in_ready  = (count_q != DEPTH[AW:0]);
   assign out_valid = (count_q != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // storage has no reset, only the pointers and the count do
   always @(posedge clk)
   begin
      if (push)
         mem[wr_ptr_q] <= in_data;
   end

   // pointers wrap naturally since depth is a power of two
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr_q <= wr_ptr_q + 1'b1;
         if (pop)
            rd_ptr_q <= rd_ptr_q + 1'b1;
         if (push & ~pop)
            count_q <= count_q + 1'b1;
         else if (pop & ~push)
            count_q <= count_q - 1'b1;
      end
   end
endmodule // spc_fifo

module spc_regs
(
   input  wire        sys_clk,
   input  wire        rst,
   input  wire        cfg_rd,
   input  wire        cfg_wr,
   input  wire [7:0]  cfg_addr,
   input  wire [31:0] cfg_wdata,
   output reg  [31:0] cfg_rdata_q,
   output reg         cfg_rvalid_q,
   input  wire        dp_rd,
   input  wire        dp_wr,
   input  wire [15:0] dp_addr,
   input  wire [31:0] dp_wdata,
   output reg  [31:0] dp_rdata_q,
   output reg         dp_rvalid_q,
   input  wire        rx_word_valid,
   input  wire [31:0] rx_word,
   output wire        rx_word_ready,
   input  wire        tx_shift_req,
   input  wire        tx_busy,
   output reg         tx_load_q,
   output reg  [31:0] transmit_shifter_q,
   input  wire        emu_halt,
   input  wire [7:0]  gen_divide,
   input  wire [11:0] frame_period,
   input  wire        tx_sync_err_evt,
   input  wire        mc_block_end_evt,
   output reg         serial_clk_run_q,
   output reg         generator_clock_q,
   output reg         generated_frame_sync_q,
   output reg         tx_irq_q,
   output reg         tx_enable_q
);
`include "spc_defs.vh"

   reg  [31:0] transmit_data_q;
   reg         free_run_q;
   reg         soft_stop_q;
   reg         frame_gen_reset_n_q;
   reg         rate_gen_reset_n_q;
   reg  [1:0]  tx_irq_source_sel_q;
   reg         tx_sync_error_q;
   reg         tx_reset_n_q;
   reg  [7:0]  div_cnt_q;
   reg  [11:0] frame_cnt_q;
   reg         gen_tick_q;
   reg         sync_err_seen_q;
   wire [31:0] port_control;
   wire [31:0] rx_head;
   wire        rx_avail;
   wire        cfg_hit_rx;
   wire        cfg_hit_tx;
   wire        cfg_hit_pc;
   wire        dp_rx_win;
   wire        rx_pop;
   wire        clk_run;
   wire        gen_edge;
   // one-hot address match, reused for reads and writes
   function hit;
      input [7:0] addr;
      input [7:0] off;
      begin
         hit = (addr == off);
      end
   endfunction
   assign cfg_hit_rx = hit(cfg_addr, `SPC_OFF_RX_DATA);
   assign cfg_hit_tx = hit(cfg_addr, `SPC_OFF_TX_DATA);
   assign cfg_hit_pc = hit(cfg_addr, `SPC_OFF_PORT_CTRL);
   // only bit 2 decoded: any address with bit 2 clear is in the receive window
   assign dp_rx_win  = ~dp_addr[`SPC_DP_WIN_BIT];
   // received words queue here; source stalls when it fills
   spc_fifo
   #(
      .WIDTH (`SPC_FIFO_WIDTH),
      .DEPTH (`SPC_FIFO_DEPTH),
      .AW    (`SPC_FIFO_AW)
   )
   u_rx_fifo
   (
      .clk       (sys_clk),
      .rst       (rst),
      .in_valid  (rx_word_valid),
      .in_ready  (rx_word_ready),
      .in_data   (rx_word),
      .out_valid (rx_avail),
      .out_ready (rx_pop),
      .out_data  (rx_head)
   );
   // a receive-window read from either bus consumes one word; both at once pop once
   assign rx_pop = (cfg_rd & cfg_hit_rx) | (dp_rd & dp_rx_win);
   // reserved and out-of-scope fields read as zero
   assign port_control = {6'h00,
                          free_run_q, soft_stop_q,
                          frame_gen_reset_n_q, rate_gen_reset_n_q,
                          tx_irq_source_sel_q, tx_sync_error_q,
                          2'b00, tx_reset_n_q, 16'h0000};
   // config bus read answer, one cycle after the strobe
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_rdata_q  <= 32'h0000_0000;
         cfg_rvalid_q <= 1'b0;
      end
      else
      begin
         cfg_rvalid_q <= cfg_rd;
         if (cfg_rd & cfg_hit_rx)
            cfg_rdata_q <= rx_avail ? rx_head : 32'h0000_0000;
         else if (cfg_rd & cfg_hit_tx)
            cfg_rdata_q <= transmit_data_q;
         else if (cfg_rd & cfg_hit_pc)
            cfg_rdata_q <= port_control;
         else if (cfg_rd)
            cfg_rdata_q <= 32'h0000_0000;
      end
   end
   // data-port read answer; transmit window reads back the held word
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         dp_rdata_q  <= 32'h0000_0000;
         dp_rvalid_q <= 1'b0;
      end
      else
      begin
         dp_rvalid_q <= dp_rd;
         if (dp_rd & dp_rx_win)
            dp_rdata_q <= rx_avail ? rx_head : 32'h0000_0000;
         else if (dp_rd)
            dp_rdata_q <= transmit_data_q;
      end
   end
   // transmit data from either bus; data port wins a same-cycle clash
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         transmit_data_q <= `SPC_TX_DATA_RST;
      else if (dp_wr & ~dp_rx_win)
         transmit_data_q <= dp_wdata;
      else if (cfg_wr & cfg_hit_tx)
         transmit_data_q <= cfg_wdata;
   end
   // whole word handed to the shifter, only while enabled
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         tx_load_q          <= 1'b0;
         transmit_shifter_q <= 32'h0000_0000;
      end
      else
      begin
         tx_load_q <= tx_shift_req & tx_reset_n_q;
         if (tx_shift_req & tx_reset_n_q)
            transmit_shifter_q <= transmit_data_q;
      end
   end
   // control fields; changing them while running is unsafe for software
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         free_run_q          <= 1'b0;
         soft_stop_q         <= 1'b0;
         frame_gen_reset_n_q <= 1'b0;
         rate_gen_reset_n_q  <= 1'b0;
         tx_irq_source_sel_q <= `SPC_IRQ_SEL_RSVD;
         tx_reset_n_q        <= 1'b0;
      end
      else if (cfg_wr & cfg_hit_pc)
      begin
         free_run_q          <= cfg_wdata[`SPC_BIT_FREE_RUN];
         soft_stop_q         <= cfg_wdata[`SPC_BIT_SOFT_STOP];
         frame_gen_reset_n_q <= cfg_wdata[`SPC_BIT_FRAME_RST_N];
         rate_gen_reset_n_q  <= cfg_wdata[`SPC_BIT_RATE_RST_N];
         tx_irq_source_sel_q <= cfg_wdata[`SPC_BIT_IRQ_SEL_HI:`SPC_BIT_IRQ_SEL_LO];
         tx_reset_n_q        <= cfg_wdata[`SPC_BIT_TX_RST_N];
      end
   end
   // sync error: event or forced write sets, write zero clears;
   // set wins over clear, and a disabled transmitter holds it clear
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         tx_sync_error_q <= 1'b0;
      else if (~tx_reset_n_q)
         tx_sync_error_q <= 1'b0;
      else if (tx_sync_err_evt |
               (cfg_wr & cfg_hit_pc & cfg_wdata[`SPC_BIT_SYNC_ERR]))
         tx_sync_error_q <= 1'b1;
      else if (cfg_wr & cfg_hit_pc)
         tx_sync_error_q <= 1'b0;
   end
   // halt gating: free-run overrides soft-stop entirely
   assign clk_run = free_run_q | ~emu_halt |
                    (soft_stop_q & tx_busy);

   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         serial_clk_run_q <= 1'b0;
      else
         serial_clk_run_q <= clk_run;
   end
   // rate generator: divider reloads from the programmed divide value
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         div_cnt_q         <= 8'h00;
         gen_tick_q        <= 1'b0;
         generator_clock_q <= 1'b0;
      end
      else if (~rate_gen_reset_n_q)
      begin
         div_cnt_q         <= gen_divide;
         gen_tick_q        <= 1'b0;
         generator_clock_q <= 1'b0;
      end
      else if (clk_run)
      begin
         gen_tick_q <= (div_cnt_q == 8'h00);
         if (div_cnt_q == 8'h00)
         begin
            div_cnt_q         <= gen_divide;
            generator_clock_q <= ~generator_clock_q;
         end
         else
            div_cnt_q <= div_cnt_q - 8'h01;
      end
      else
         gen_tick_q <= 1'b0;
   end
   // one frame count per full generator clock, on its rising half
   assign gen_edge = gen_tick_q & generator_clock_q;
   // frame generator: period loads on reset, sync fires at count zero
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         frame_cnt_q            <= 12'h000;
         generated_frame_sync_q <= 1'b0;
      end
      else if (~frame_gen_reset_n_q | ~rate_gen_reset_n_q)
      begin
         frame_cnt_q            <= frame_period;
         generated_frame_sync_q <= 1'b0;
      end
      else if (gen_edge)
      begin
         generated_frame_sync_q <= (frame_cnt_q == 12'h000);
         if (frame_cnt_q == 12'h000)
            frame_cnt_q <= frame_period;
         else
            frame_cnt_q <= frame_cnt_q - 12'h001;
      end
      else
         generated_frame_sync_q <= 1'b0;
   end
   // transmit interrupt: one-clock pulse from the chosen source
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         tx_irq_q        <= 1'b0;
         sync_err_seen_q <= 1'b0;
         tx_enable_q     <= 1'b0;
      end
      else
      begin
         sync_err_seen_q <= tx_sync_error_q;
         tx_enable_q     <= tx_reset_n_q;
         case (tx_irq_source_sel_q)
            `SPC_IRQ_SEL_BLOCK:
               tx_irq_q <= mc_block_end_evt;
            `SPC_IRQ_SEL_FSYNC:
               tx_irq_q <= generated_frame_sync_q;
            `SPC_IRQ_SEL_SYNCERR:
               tx_irq_q <= tx_sync_error_q & ~sync_err_seen_q;
            default:
               tx_irq_q <= 1'b0;
         endcase
      end
   end
endmodule // spc_regs

// ===== verification/spc_host.sv
// host model: cpu and dma master on the config and data-port buses
module spc_host (
   input  wire logic        sys_clk,
   output logic             cfg_rd,
   output logic             cfg_wr,
   output logic [7:0]       cfg_addr,
   output logic [31:0]      cfg_wdata,
   input  wire logic [31:0] cfg_rdata_q,
   input  wire logic        cfg_rvalid_q,
   output logic             dp_rd,
   output logic             dp_wr,
   output logic [15:0]      dp_addr,
   output logic [31:0]      dp_wdata,
   input  wire logic [31:0] dp_rdata_q,
   input  wire logic        dp_rvalid_q
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus from time zero
   initial
      {cfg_rd, cfg_wr, dp_rd, dp_wr, cfg_addr, dp_addr, cfg_wdata, dp_wdata} = '0;

   // one strobe cycle; answer taken at the falling edge after acceptance
   task automatic xfer(input bit dp, input bit wr, input logic [15:0] a,
                       input logic [31:0] wd, output logic [31:0] rdat);
      @(negedge sys_clk);
      if (dp)
         {dp_rd, dp_wr, dp_addr, dp_wdata} = {!wr, wr, a, wd};
      else
         {cfg_rd, cfg_wr, cfg_addr, cfg_wdata} = {!wr, wr, a[7:0], wd};
      @(negedge sys_clk);
      {cfg_rd, cfg_wr, dp_rd, dp_wr} = 4'h0;
      // idle data lines never repeat the last word
      cfg_wdata = ~cfg_wdata;
      dp_wdata = ~dp_wdata;
      rdat = dp ? dp_rdata_q : cfg_rdata_q;
      if (!wr && (dp ? dp_rvalid_q : cfg_rvalid_q) !== 1'b1)
         rdat = 32'hxxxx_xxxx; // a missing answer never matches
   endtask
endmodule // spc_host

// ===== verification/spc_regs_sva.sv
// pin-level assertions for the serial port control register bank
module spc_regs_sva (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        cfg_rd,
   input wire logic        cfg_wr,
   input wire logic [7:0]  cfg_addr,
   input wire logic [31:0] cfg_wdata,
   input wire logic        cfg_rvalid_q,
   input wire logic        tx_busy,
   input wire logic        emu_halt,
   input wire logic        mc_block_end_evt,
   input wire logic        serial_clk_run_q,
   input wire logic        generated_frame_sync_q,
   input wire logic        tx_irq_q
);
   logic [5:0] ctl_q; // control bits 25..20 as last written

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // shadow of the control fields; only config writes reach them
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         ctl_q <= 6'h00;
      else if (cfg_wr && cfg_addr == 8'h08)
         ctl_q <= cfg_wdata[25:20];

   read_answer_a: assert property (cfg_rvalid_q == $past(cfg_rd))
      else $error("read answer mismatch");
   frame_held_a: assert property (!ctl_q[3] && $past(!ctl_q[3])
      |-> !generated_frame_sync_q) else $error("frame sync while held");
   fsync_pulse_a: assert property (generated_frame_sync_q |=> !generated_frame_sync_q)
      else $error("frame sync too long");
   free_run_a: assert property ($past(ctl_q[5]) |-> serial_clk_run_q)
      else $error("clock stopped in free run");
   hard_stop_a: assert property ($past(!ctl_q[5] && !ctl_q[4] && emu_halt)
      |-> !serial_clk_run_q) else $error("clock ran on halt");
   soft_stop_a: assert property ($past(!ctl_q[5] && ctl_q[4] && emu_halt)
      |-> serial_clk_run_q == $past(tx_busy)) else $error("soft stop wrong");
   irq_block_a: assert property (mc_block_end_evt && ctl_q[1:0] == 2'h1 |=> tx_irq_q)
      else $error("no block interrupt");
   irq_frame_a: assert property (generated_frame_sync_q && ctl_q[1:0] == 2'h2
      |=> tx_irq_q) else $error("no frame interrupt");

   cover property (generated_frame_sync_q);
   cover property (!serial_clk_run_q);
   cover property (tx_irq_q);
endmodule // spc_regs_sva

// ===== verification/spc_regs_test.sv
// self-checking bench for the serial port control register bank
module spc_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, rst, cfg_rd, cfg_wr, cfg_rvalid_q, dp_rd, dp_wr, dp_rvalid_q, s;
   logic [7:0]  cfg_addr, gen_divide;
   logic [11:0] frame_period;
   logic [15:0] dp_addr;
   logic [31:0] cfg_wdata, cfg_rdata_q, dp_wdata, dp_rdata_q, rx_word, transmit_shifter_q;
   logic        rx_word_valid, rx_word_ready, tx_shift_req, tx_busy, tx_load_q, emu_halt;
   logic        tx_sync_err_evt, mc_block_end_evt, serial_clk_run_q, generator_clock_q;
   logic        generated_frame_sync_q, tx_irq_q, tx_enable_q;
   int          bad_count, n_compared, i, n, e;

   spc_regs u_spc_regs (
      .sys_clk(sys_clk), .rst(rst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q),
      .dp_rd(dp_rd), .dp_wr(dp_wr), .dp_addr(dp_addr), .dp_wdata(dp_wdata),
      .dp_rdata_q(dp_rdata_q), .dp_rvalid_q(dp_rvalid_q), .rx_word_valid(rx_word_valid),
      .rx_word(rx_word), .rx_word_ready(rx_word_ready), .tx_shift_req(tx_shift_req),
      .tx_busy(tx_busy), .tx_load_q(tx_load_q), .transmit_shifter_q(transmit_shifter_q),
      .emu_halt(emu_halt), .gen_divide(gen_divide), .frame_period(frame_period),
      .tx_sync_err_evt(tx_sync_err_evt), .mc_block_end_evt(mc_block_end_evt),
      .serial_clk_run_q(serial_clk_run_q), .generator_clock_q(generator_clock_q),
      .generated_frame_sync_q(generated_frame_sync_q), .tx_irq_q(tx_irq_q),
      .tx_enable_q(tx_enable_q));
   spc_host u_host (
      .sys_clk(sys_clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q),
      .dp_rd(dp_rd), .dp_wr(dp_wr), .dp_addr(dp_addr), .dp_wdata(dp_wdata),
      .dp_rdata_q(dp_rdata_q), .dp_rvalid_q(dp_rvalid_q));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input bit dp = 0);
      logic [31:0] x;
      u_host.xfer(dp, 1'b1, a, d, x);
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] exp, input bit dp = 0);
      logic [31:0] x;
      u_host.xfer(dp, 1'b0, a, 32'h0000_0000, x);
      chk(x, exp);
   endtask
   task automatic pulse(ref logic p);
      @(negedge sys_clk);
      p = 1;
      @(negedge sys_clk);
      p = 0;
   endtask
   // any interrupt pulse within five cycles
   task automatic irq_seen(input logic exp);
      s = tx_irq_q;
      repeat (5)
      begin
         @(negedge sys_clk);
         s = s | tx_irq_q;
      end
      chk(32'(s), 32'(exp));
   endtask
   task automatic conclude;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // 125 MHz clock
   initial
   begin
      sys_clk = 0;
      forever #4 sys_clk = ~sys_clk;
   end
   // the run needs under three hundred cycles; ten thousand means a hang
   initial
   begin
      #80000;
      bad_count++;
      conclude();
   end

   initial
   begin
      {rst, rx_word_valid, tx_shift_req, tx_busy, emu_halt} = 5'h10;
      {tx_sync_err_evt, mc_block_end_evt} = 2'h0;
      rx_word = 32'h0000_0000;
      gen_divide = 8'h01;
      frame_period = 12'h002;
      repeat (16) @(negedge sys_clk);
      rst = 0;
      rd(16'h0008, 32'h0000_0000);
      rd(16'h00C0, 32'h0000_0000);
      wr(16'h0008, 32'hFFF7_FFFF);
      rd(16'h0008, 32'h03F1_0000);
      wr(16'h0008, 32'h0000_0000);
      // fill the fifo until it refuses, then drain it from both buses
      rx_word_valid = 1;
      for (i = 0; i < 17; i++)
      begin
         rx_word = 32'hA5A5_0000 + i;
         @(negedge sys_clk);
      end
      chk(32'(rx_word_ready), 32'h0);
      for (i = 0; i < 17; i++)
      begin
         rd(i[0] ? {4'h0, i[7:0], 4'h8} : 16'h0000, 32'hA5A5_0000 + i, i[0]);
         if (i == 0)
         begin
            @(negedge sys_clk);
            rx_word_valid = 0;
            rx_word = ~rx_word;
         end
      end
      rd(16'h0000, 32'h0000_0000);
      wr(16'h0004, 32'h1234_5678);
      rd(16'h0004, 32'h1234_5678);
      wr(16'h0204, 32'hCAFE_F00D, 1);
      rd(16'h0004, 32'hCAFE_F00D);
      rd(16'h0A0C, 32'hCAFE_F00D, 1);
      wr(16'h0008, 32'h0001_0000);
      pulse(tx_shift_req);
      chk(32'(tx_load_q), 32'h1);
      chk(transmit_shifter_q, 32'hCAFE_F00D);
      chk(32'(tx_enable_q), 32'h1);
      wr(16'h0008, 32'h0000_0000);
      pulse(tx_shift_req);
      chk(32'(tx_load_q), 32'h0);
      // interrupt sources 0, 1 and 3; 2 follows with the frame sync
      wr(16'h0008, 32'h0001_0000);
      pulse(mc_block_end_evt);
      irq_seen(0);
      wr(16'h0008, 32'h0011_0000);
      pulse(mc_block_end_evt);
      irq_seen(1);
      wr(16'h0008, 32'h0031_0000);
      pulse(tx_sync_err_evt);
      irq_seen(1);
      rd(16'h0008, 32'h0039_0000);
      wr(16'h0008, 32'h0038_0000);
      rd(16'h0008, 32'h0030_0000);
      wr(16'h0008, 32'h0031_0000);
      wr(16'h0008, 32'h0039_0000);
      irq_seen(1);
      rd(16'h0008, 32'h0039_0000);
      // rate generator alone gives no frame sync, but its clock runs
      chk(32'(generator_clock_q), 32'h0);
      wr(16'h0008, 32'h0061_0000);
      irq_seen(0);
      n = 0;
      repeat (8)
      begin
         s = generator_clock_q;
         @(negedge sys_clk);
         n += (s != generator_clock_q);
      end
      chk(n, 8 / (gen_divide + 1));
      wr(16'h0008, 32'h00E1_0000);
      e = (frame_period + 1) * 2 * (gen_divide + 1);
      n = 0;
      while (generated_frame_sync_q !== 1'b1 && n < 40)
      begin
         @(negedge sys_clk);
         n++;
      end
      chk(32'(n >= e - 2 && n <= e + 3), 32'h1);
      @(negedge sys_clk);
      chk(32'(tx_irq_q), 32'h1);
      // every free, soft, halt and busy combination
      for (i = 0; i < 16; i++)
      begin
         wr(16'h0008, {6'h00, i[3:2], 24'h00_0000});
         emu_halt = i[1];
         tx_busy = i[0];
         repeat (2) @(negedge sys_clk);
         chk(32'(serial_clk_run_q), 32'(i[3] | !i[1] | (i[2] & i[0])));
      end
      conclude();
   end
endmodule // spc_regs_test

bind spc_regs spc_regs_sva u_spc_regs_sva (
   .sys_clk(sys_clk), .rst(rst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
   .cfg_wdata(cfg_wdata), .cfg_rvalid_q(cfg_rvalid_q), .tx_busy(tx_busy),
   .emu_halt(emu_halt), .mc_block_end_evt(mc_block_end_evt),
   .serial_clk_run_q(serial_clk_run_q), .generated_frame_sync_q(generated_frame_sync_q),
   .tx_irq_q(tx_irq_q));
